// >>> include/aor_pkg.sv
package aor_pkg;
    // ************************************************
    // sizes and codes
    // ************************************************
    localparam int          CHANNELS     = 6;
    localparam int          SAMPLE_W     = 16;
    localparam int          OS_W         = 3;
    localparam int          ACC_W        = SAMPLE_W + 7;
    localparam logic [2:0]  OS_NONE      = 3'h0;
    localparam logic [2:0]  OS_MAX_CODE  = 3'h6;
    localparam logic [3:0]  MODE_WORD    = 4'h0;
    // ************************************************
    // timing
    // ************************************************
    localparam int          CLK_NS       = 5;
    localparam int          CONV_NS      = 4000;
    localparam int          CONV_CYC     = CONV_NS / CLK_NS;
    localparam int          FIFO_DEPTH   = 4;

    typedef enum logic [1:0] {
        AOR_WORD   = 2'h0,
        AOR_BYTE   = 2'h1,
        AOR_SERIAL = 2'h2
    } aor_mode_t;

    typedef struct packed {
        logic [2:0]          channel;
        logic [SAMPLE_W-1:0] value;
    } aor_sample_t;
endpackage

// >>> design/aor_fifo.sv
`timescale 1ns/100ps
module aor_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
            // registered so the stall reaches the source straight from a flop
            in_ready <= (next_count != (AW+1)'(DEPTH));
        end
    end
endmodule

// >>> design/aor_ctrl.sv
`timescale 1ns/100ps
// Behaviour
// - result reads are served while busy is high and converting
// - reads during conversion return the previously completed sample set
// - reading during conversion works in word, byte and serial modes, any ratio
// - output registers load new results on the same clock edge that busy falls
// - oversample select is latched at busy fall, used for next conversion
// - busy lasts longer as the oversampling ratio rises
// - with oversampling, converter output is averaged before reaching the host
// - chip select high floats serial outputs and flag, ignores shift clock
module aor_ctrl #(
    parameter int CONV_CYCLES = aor_pkg::CONV_CYC
) (
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    input  wire logic                         conv_start_group_a,
    input  wire logic                         conv_start_group_b,
    input  wire logic [aor_pkg::OS_W-1:0]     oversample_select,
    input  wire logic [1:0]                   read_mode,
    input  wire logic                         chip_select_n,
    input  wire logic                         read_strobe_n,
    input  wire logic                         shift_clock,
    input  wire logic                         msb_first,
    // converter samples, one channel per beat
    input  wire logic                         adc_valid,
    output logic                              adc_ready,
    input  wire aor_pkg::aor_sample_t         adc_sample,
    output logic                              busy,
    output logic [aor_pkg::OS_W-1:0]          oversampling_ratio,
    output logic [aor_pkg::SAMPLE_W-1:0]      parallel_data,
    output logic                              parallel_data_oe,
    output logic                              serial_out_primary,
    output logic                              serial_out_primary_oe,
    output logic                              serial_out_secondary,
    output logic                              serial_out_secondary_oe,
    output logic                              first_channel_flag,
    output logic                              first_channel_flag_oe
);
    localparam int N  = aor_pkg::CHANNELS;
    localparam int W  = aor_pkg::SAMPLE_W;
    localparam int AC = aor_pkg::ACC_W;
    // timer must hold the longest busy, at the largest ratio
    localparam int CW = $clog2((CONV_CYCLES << aor_pkg::OS_MAX_CODE) + 1);

    // ************************************************
    // pin synchronisers
    // ************************************************
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    logic [4:0] pin_prev;
    always_ff @(posedge clk_sys) begin
        pin_meta <= {conv_start_group_a, chip_select_n, read_strobe_n, shift_clock,
                     conv_start_group_b};
        pin_sync <= pin_meta;
        pin_prev <= pin_sync;
    end
    logic conv_rise;
    logic cs_n;
    logic rd_fall;
    logic sck_rise;
    logic sck_fall;
    // starts are assumed driven together; group a alone triggers
    assign conv_rise = pin_sync[4] && !pin_prev[4];
    assign cs_n      = pin_sync[3];
    assign rd_fall   = !pin_sync[2] && pin_prev[2];
    assign sck_rise  = pin_sync[1] && !pin_prev[1];
    assign sck_fall  = !pin_sync[1] && pin_prev[1];

    // ************************************************
    // conversion sequencing
    // ************************************************
    typedef enum logic [1:0] {
        AOR_IDLE = 2'b00,
        AOR_CONV = 2'b01,
        AOR_LOAD = 2'b10
    } aor_state_t;
    aor_state_t      state;
    logic [CW-1:0]   timer;
    logic [AC-1:0]   acc [N];
    logic [W-1:0]    result [N];
    logic            fifo_valid;
    logic            fifo_ready;
    logic [$bits(aor_pkg::aor_sample_t)-1:0] fifo_word;
    aor_pkg::aor_sample_t fifo_sample;
    assign fifo_sample = aor_pkg::aor_sample_t'(fifo_word);
    // fifo drain stalls outside a conversion, so the fifo really fills
    assign fifo_ready = (state == AOR_CONV);

    aor_fifo #(
        .WIDTH ($bits(aor_pkg::aor_sample_t)),
        .DEPTH (aor_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (adc_valid),
        .in_ready  (adc_ready),
        .in_data   (adc_sample),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_word)
    );

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state              <= AOR_IDLE;
            busy               <= 1'b0;
            timer              <= '0;
            oversampling_ratio <= aor_pkg::OS_NONE;
        end else begin
            unique case (state)
                AOR_IDLE: begin
                    if (conv_rise) begin
                        state <= AOR_CONV;
                        busy  <= 1'b1;
                        timer <= CW'(CONV_CYCLES) << oversampling_ratio;
                    end
                end
                AOR_CONV: begin
                    timer <= timer - 1'b1;
                    if (timer == CW'(1)) begin
                        state <= AOR_LOAD;
                    end
                end
                AOR_LOAD: begin
                    state <= AOR_IDLE;
                    busy  <= 1'b0;
                    // clamp codes above the largest ratio
                    oversampling_ratio <= (oversample_select > aor_pkg::OS_MAX_CODE) ?
                        aor_pkg::OS_MAX_CODE : oversample_select;
                end
                default: state <= AOR_IDLE;
            endcase
        end
    end

    // ************************************************
    // averaging filter and result registers
    // ************************************************
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ch
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    acc[g]    <= '0;
                    result[g] <= '0;
                end else if (state == AOR_IDLE && conv_rise) begin
                    acc[g] <= '0;
                end else if (fifo_valid && fifo_ready && fifo_sample.channel == 3'(g)) begin
                    acc[g] <= acc[g] + AC'(fifo_sample.value);
                end else if (state == AOR_LOAD) begin
                    // shift by code divides by the power-of-two ratio
                    result[g] <= W'(acc[g] >> oversampling_ratio);
                end
            end
        end
    endgenerate

    // ************************************************
    // host read port, live during busy
    // ************************************************
    logic [3:0] word_idx;
    logic [4:0] bit_idx;
    logic       byte_hi;
    logic [2:0] ch_a;
    logic [2:0] ch_b;
    assign ch_a = 3'(word_idx % 4'(N));
    assign ch_b = 3'((word_idx + 4'(N/2)) % 4'(N));

    // no busy gating: reads see result[], which only moves in AOR_LOAD
    always_ff @(posedge clk_sys) begin
        if (rst || cs_n) begin
            word_idx                <= aor_pkg::MODE_WORD;
            bit_idx                 <= '0;
            byte_hi                 <= 1'b0;
            parallel_data           <= '0;
            parallel_data_oe        <= 1'b0;
            serial_out_primary      <= 1'b0;
            serial_out_secondary    <= 1'b0;
            serial_out_primary_oe   <= 1'b0;
            serial_out_secondary_oe <= 1'b0;
            first_channel_flag      <= 1'b0;
            first_channel_flag_oe   <= 1'b0;
        end else if (read_mode == aor_pkg::AOR_SERIAL) begin
            serial_out_primary_oe   <= 1'b1;
            serial_out_secondary_oe <= 1'b1;
            first_channel_flag_oe   <= 1'b1;
            serial_out_primary      <= result[ch_a][4'(W-1) - bit_idx[3:0]];
            serial_out_secondary    <= result[ch_b][4'(W-1) - bit_idx[3:0]];
            first_channel_flag      <= (ch_a == 3'h0);
            if (sck_rise && bit_idx != '0) begin
                if (bit_idx == 5'(W)) begin
                    bit_idx  <= '0;
                    word_idx <= word_idx + 1'b1;
                end
            end
            if (sck_fall) begin
                bit_idx <= bit_idx + 1'b1;
                if (bit_idx == 5'(W-1)) begin
                    bit_idx  <= '0;
                    word_idx <= (word_idx == 4'(N-1)) ? '0 : word_idx + 1'b1;
                end
            end
        end else if (rd_fall) begin
            parallel_data_oe      <= 1'b1;
            first_channel_flag_oe <= 1'b1;
            first_channel_flag    <= (ch_a == 3'h0);
            if (read_mode == aor_pkg::AOR_BYTE) begin
                parallel_data <= {{(W/2){1'b0}}, (byte_hi ^ msb_first) ?
                                  result[ch_a][W-1:W/2] : result[ch_a][W/2-1:0]};
                byte_hi <= !byte_hi;
                if (byte_hi) begin
                    word_idx <= (word_idx == 4'(N-1)) ? '0 : word_idx + 1'b1;
                end
            end else begin
                parallel_data <= result[ch_a];
                word_idx      <= (word_idx == 4'(N-1)) ? '0 : word_idx + 1'b1;
            end
        end
    end
endmodule

// >>> dv/aor_ctrl_props.sv
`timescale 1ns/100ps
// ************************************************
// port checker for the control block
// ************************************************
module aor_ctrl_props #(
    parameter int CONV_CYCLES = aor_pkg::CONV_CYC
) (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       conv_start_group_a,
    input wire logic [2:0] oversample_select,
    input wire logic [1:0] read_mode,
    input wire logic       chip_select_n,
    input wire logic       read_strobe_n,
    input wire logic       busy,
    input wire logic [2:0] oversampling_ratio,
    input wire logic       parallel_data_oe,
    input wire logic       serial_out_primary_oe,
    input wire logic       serial_out_secondary_oe,
    input wire logic       first_channel_flag_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // cycles busy has stood high; too long for a repetition, so counted
    int run;
    always_ff @(posedge clk_sys) begin
        run <= (rst || !busy) ? 0 : run + 1;
    end
    AST_BUSY_RISE: assert property (
        $rose(conv_start_group_a) && !busy |-> ##[1:5] busy)
        else $error("busy did not rise after start");
    AST_BUSY_LEN: assert property (
        $fell(busy) |-> run == (CONV_CYCLES << $past(oversampling_ratio)) + 1)
        else $error("busy length does not match ratio");
    AST_RATIO_CAP: assert property (
        oversampling_ratio <= aor_pkg::OS_MAX_CODE)
        else $error("ratio above largest code");
    AST_RATIO_LATCH: assert property (
        $fell(busy) |-> ##[0:2] oversampling_ratio ==
            (oversample_select > 3'h6 ? 3'h6 : oversample_select))
        else $error("ratio not latched at done");
    AST_RATIO_HOLD: assert property (
        $changed(oversampling_ratio) |-> !busy && ($past(busy) || $past(busy, 2)))
        else $error("ratio changed away from done");
    AST_TRI_CS: assert property (
        chip_select_n [*6] |-> !parallel_data_oe && !serial_out_primary_oe &&
            !serial_out_secondary_oe && !first_channel_flag_oe)
        else $error("outputs driven while deselected");
    AST_READ_BUSY: assert property (
        (busy && !chip_select_n && !read_strobe_n && read_mode == 2'h0) [*6] |->
            parallel_data_oe)
        else $error("read refused during conversion");
    AST_SER_OE: assert property (
        (!chip_select_n && read_mode == 2'h2) [*6] |->
            serial_out_primary_oe && serial_out_secondary_oe)
        else $error("serial output not driven");
    cover property ($fell(busy) && $past(oversampling_ratio) == 3'h6);
    cover property (busy && serial_out_primary_oe);
    cover property (busy && parallel_data_oe);
endmodule
bind aor_ctrl aor_ctrl_props #(.CONV_CYCLES(CONV_CYCLES)) props_u (.clk_sys, .rst,
    .conv_start_group_a, .oversample_select, .read_mode, .chip_select_n, .read_strobe_n, .busy,
    .oversampling_ratio, .parallel_data_oe, .serial_out_primary_oe, .serial_out_secondary_oe,
    .first_channel_flag_oe);

// >>> dv/aor_conv_model.sv
`timescale 1ns/100ps
// ************************************************
// converter sample source
// ************************************************
module aor_conv_model (
    input  wire logic            clk_sys,
    input  wire logic            busy,
    input  wire logic [2:0]      ratio,
    input  wire logic [15:0]     base,
    input  wire logic            adc_ready,
    output logic                 adc_valid,
    output aor_pkg::aor_sample_t adc_sample
);
    int seed = 56;
    logic [2:0] r;
    logic [15:0] b;
    initial begin
        adc_valid = 1'b0;
        adc_sample = '0;
        forever begin
            @(posedge busy);
            r = ratio;
            b = base;
            // odd passes add 2, so the mean shows whether averaging happened
            for (int i = 0; i < (6 << r); i++) begin
                @(posedge clk_sys);
                if ($random(seed) & 1) @(posedge clk_sys);
                #1;
                adc_valid = 1'b1;
                adc_sample.channel = 3'(i % 6);
                adc_sample.value = b + 16'((i % 6) * 256) + (((i / 6) % 2) ? 16'h0002 : 16'h0000);
                do @(posedge clk_sys); while (adc_ready !== 1'b1);
                #1;
                adc_valid = 1'b0;
                adc_sample = ~adc_sample;
            end
        end
    end
endmodule

// >>> dv/aor_ctrl_test.sv
`timescale 1ns/100ps
// ************************************************
// bench for the control block
// ************************************************
module aor_ctrl_test;
    localparam int CC = 32;
    logic clk_sys, rst, start, chip_select_n, read_strobe_n, shift_clock, look;
    logic adc_valid, adc_ready, busy, serial_out_primary, serial_out_secondary, last_r;
    logic first_channel_flag, msb_first, flag_seen;
    logic [2:0] oversample_select, oversampling_ratio;
    logic [1:0] read_mode;
    logic [15:0] base, got, got2, parallel_data, last_base;
    aor_pkg::aor_sample_t adc_sample;
    logic [15:0] expq[$];
    int failures = 0;
    int tests_run = 0;
    int seed = 56;
    int cycles = 0;
    aor_ctrl #(.CONV_CYCLES(CC)) dut_u (.clk_sys, .rst, .conv_start_group_a(start),
        .conv_start_group_b(start), .oversample_select, .read_mode, .chip_select_n,
        .read_strobe_n, .shift_clock, .msb_first, .adc_valid, .adc_ready, .adc_sample,
        .busy, .oversampling_ratio, .parallel_data, .parallel_data_oe(), .serial_out_primary,
        .serial_out_primary_oe(), .serial_out_secondary, .serial_out_secondary_oe(),
        .first_channel_flag, .first_channel_flag_oe());
    aor_conv_model model_u (.clk_sys, .busy, .ratio(oversampling_ratio), .base, .adc_ready,
        .adc_valid, .adc_sample);
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // monitor: oldest note against each assembled result
    always @(posedge clk_sys) if (look === 1'b1) chk("read data", expq.pop_front(), got);
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            give_verdict;
        end
    end
    // reads all six channels; serial takes both lines, secondary starts half way round
    task rd(input logic [1:0] m);
        read_mode = m;
        chip_select_n = 1'b0;
        cyc(4);
        for (int ch = 0; ch < 6; ch++) begin
            expq.push_back(last_base + 16'(ch * 256) + 16'(last_r));
            if (m == 2'h2) begin
                expq.push_back(last_base + 16'(((ch + 3) % 6) * 256) + 16'(last_r));
            end
            expq.push_back(16'(ch == 0));
            for (int u = 0; u < (m == 2'h0 ? 1 : m == 2'h1 ? 2 : 16); u++) begin
                if (m == 2'h2) begin
                    if (u > 0 || ch > 0) begin
                        shift_clock = 1'b1;
                        cyc(6);
                        shift_clock = 1'b0;
                    end
                    cyc(6);
                    got = {got[14:0], serial_out_primary};
                    got2 = {got2[14:0], serial_out_secondary};
                end else begin
                    read_strobe_n = 1'b0;
                    cyc(6);
                    if (m == 2'h0) got = parallel_data;
                    else if (msb_first) got = {got[7:0], parallel_data[7:0]};
                    else got = {parallel_data[7:0], got[15:8]};
                    read_strobe_n = 1'b1;
                    cyc(4);
                end
            end
            flag_seen = first_channel_flag;
            look = 1'b1;
            cyc(1);
            if (m == 2'h2) begin
                got = got2;
                cyc(1);
            end
            got = 16'(flag_seen);
            cyc(1);
            look = 1'b0;
        end
        chip_select_n = 1'b1;
    endtask
    task conv(input logic [2:0] code, input logic during, input logic [1:0] m);
        int n;
        logic [2:0] r;
        base = 16'($random(seed)) & 16'h3FFF;
        oversample_select = code;
        r = oversampling_ratio;
        start = 1'b1;
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        chk("busy rise", 16'h0001, 16'(busy));
        start = 1'b0;
        if (during) rd(m);
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin
            cyc(1);
            n++;
        end
        chk("busy", 16'h0000, 16'(busy));
        if (!during) chk("busy cycles", 16'((CC << r) + 1), 16'(n));
        cyc(3);
        chk("ratio", (code > 3'h6) ? 16'h0006 : 16'(code), 16'(oversampling_ratio));
        last_base = base;
        last_r = (r != 3'h0);
        if (!during) rd(m);
    endtask
    initial begin
        rst = 1'b1;
        {start, shift_clock, look, last_r, msb_first} = 5'h01;
        {chip_select_n, read_strobe_n} = 2'h3;
        {oversample_select, read_mode} = 5'h00;
        {base, last_base, got, got2} = 64'h0;
        cyc(2);
        rst = 1'b0;
        cyc(3);
        for (int i = 0; i < 8; i++) begin
            conv(3'(i), 1'b0, 2'(i % 3));
            $display("code %0d done", i);
        end
        // code 7 clamps to 6, so these run long enough to read inside busy
        for (int m = 0; m < 3; m++) begin
            // byte mode here takes the low byte first
            msb_first = (m != 1);
            conv(3'h6, 1'b1, 2'(m));
            $display("read during conversion mode %0d done", m);
        end
        give_verdict;
    end
endmodule
